// File: common/cts_params.svh
`ifndef CTS_PARAMS_SVH
`define CTS_PARAMS_SVH

// processing time base and clock rate
`define CTS_TICK_MS          5
`define CTS_CLK_KHZ          25000
`define CTS_TICK_CYCLES      (`CTS_CLK_KHZ * `CTS_TICK_MS)

// widths of measured values and settings
`define CTS_CUR_W            16
`define CTS_WIDE_W           20
`define CTS_RATIO_W          14
`define CTS_DELAY_W          21
`define CTS_PROD_W           36

// threshold hysteresis in percent of the setting
`define CTS_HYST_DROP_PCT    97
`define CTS_HYST_RISE_PCT    103
`define CTS_PCT_DIV          100

// ratio settings are in 0.01 % steps, so full scale is 100.00 %
`define CTS_RATIO_FULL       10000

// sqrt(3)/2 as a 10-bit binary fraction for the sequence operator
`define CTS_SQRT3_HALF       887
`define CTS_SQRT3_SHIFT      10

// magnitude estimate: max + 3/8 * min
`define CTS_MAG_BETA_NUM     3
`define CTS_MAG_BETA_SHIFT   3

// reset values
`define CTS_OFFSET_RST       20'h00000
`define CTS_ELAPSED_RST      22'h000000

`endif

// File: common/cts_pkg.sv
package cts_pkg;

	typedef enum logic [1:0] {
		RES_NONE = 2'h0,
		RES_ONE  = 2'h1,
		RES_TWO  = 2'h2
	} residual_sel_e;

	typedef enum logic [1:0] {
		FORCE_NORMAL  = 2'h0,
		FORCE_ALARM   = 2'h1,
		FORCE_BLOCKED = 2'h2
	} force_e;

	typedef enum logic [3:0] {
		ST_NORMAL  = 4'h1,
		ST_START   = 4'h2,
		ST_ALARM   = 4'h4,
		ST_BLOCKED = 4'h8
	} state_e;

endpackage : cts_pkg

// File: core/mag_approx.sv
`include "cts_params.svh"

// phasor magnitude estimate; worst error about 7 %, traded for no root
module mag_approx (
	input  wire logic signed [`CTS_WIDE_W-1:0] re,
	input  wire logic signed [`CTS_WIDE_W-1:0] im,
	output logic             [`CTS_WIDE_W-1:0] mag
);
	logic [`CTS_WIDE_W-1:0] abs_re;
	logic [`CTS_WIDE_W-1:0] abs_im;
	logic [`CTS_WIDE_W-1:0] big;
	logic [`CTS_WIDE_W+1:0] small_scaled;

	// absolute values, then largest plus a fraction of the smallest
	always_comb begin
		abs_re = re[`CTS_WIDE_W-1] ? 20'(-re) : 20'(re);
		abs_im = im[`CTS_WIDE_W-1] ? 20'(-im) : 20'(im);
		big = (abs_re > abs_im) ? abs_re : abs_im;
		small_scaled = 22'((abs_re > abs_im) ? abs_im : abs_re) * 22'(`CTS_MAG_BETA_NUM);
		mag = big + 20'(small_scaled >> `CTS_MAG_BETA_SHIFT);
	end

endmodule : mag_approx

// File: core/sequence_calc.sv
`include "cts_params.svh"

// symmetrical components from three phase phasors
module sequence_calc (
	input  wire logic signed [`CTS_WIDE_W-1:0] a_re,
	input  wire logic signed [`CTS_WIDE_W-1:0] a_im,
	input  wire logic signed [`CTS_WIDE_W-1:0] b_re,
	input  wire logic signed [`CTS_WIDE_W-1:0] b_im,
	input  wire logic signed [`CTS_WIDE_W-1:0] c_re,
	input  wire logic signed [`CTS_WIDE_W-1:0] c_im,
	output logic signed      [`CTS_WIDE_W-1:0] pos_re,
	output logic signed      [`CTS_WIDE_W-1:0] pos_im,
	output logic signed      [`CTS_WIDE_W-1:0] neg_re,
	output logic signed      [`CTS_WIDE_W-1:0] neg_im
);
	logic signed [31:0] kb_re;
	logic signed [31:0] kb_im;
	logic signed [31:0] kc_re;
	logic signed [31:0] kc_im;
	logic signed [31:0] half_bc_re;
	logic signed [31:0] half_bc_im;

	// a*X and a^2*X share the -X/2 part and differ in the sign of sqrt(3)/2 terms
	always_comb begin
		kb_re = (32'(b_re) * 32'sd`CTS_SQRT3_HALF) >>> `CTS_SQRT3_SHIFT;
		kb_im = (32'(b_im) * 32'sd`CTS_SQRT3_HALF) >>> `CTS_SQRT3_SHIFT;
		kc_re = (32'(c_re) * 32'sd`CTS_SQRT3_HALF) >>> `CTS_SQRT3_SHIFT;
		kc_im = (32'(c_im) * 32'sd`CTS_SQRT3_HALF) >>> `CTS_SQRT3_SHIFT;
		half_bc_re = (32'(b_re) + 32'(c_re)) >>> 1;
		half_bc_im = (32'(b_im) + 32'(c_im)) >>> 1;
		// positive: Ia + a*Ib + a^2*Ic, over three
		pos_re = 20'((32'(a_re) - half_bc_re - kb_im + kc_im) / 32'sd3);
		pos_im = 20'((32'(a_im) - half_bc_im + kb_re - kc_re) / 32'sd3);
		// negative: Ia + a^2*Ib + a*Ic, over three
		neg_re = 20'((32'(a_re) - half_bc_re + kb_im - kc_im) / 32'sd3);
		neg_im = 20'((32'(a_im) - half_bc_im - kb_re + kc_re) / 32'sd3);
	end

endmodule : sequence_calc

// File: core/current_transformer_supervision.sv
// Function
// - sample phase phasors every 5 ms tick
// - supervise phase angle via full phasors
// - derive positive and negative sequence currents
// - residual source: none, channel one, two
// - residual sum check switchable by configuration
// - no phase above upper threshold
// - some phase above lower threshold
// - some phase below lower threshold
// - min over max phase below ratio
// - negative over positive above sequence ratio
// - phase plus residual sum exceeds mismatch
// - alarm after conditions hold for delay
// - residual polarity add or subtract, add default
// - compensate stores present phase plus residual sum as offset, only while some phase is above lower threshold
// - forced status only under global forcing enable
// - general settings independent of setting group
// - 97 and 103 percent threshold hysteresis
// - block sampled each cycle suppresses start, alarm
`include "cts_params.svh"

module current_transformer_supervision #(
	parameter int unsigned TICK_CYCLES = `CTS_TICK_CYCLES
) (
	input  wire logic                           clk,
	input  wire logic                           reset,
	input  wire logic signed [`CTS_CUR_W-1:0]   phase_a_current_re,
	input  wire logic signed [`CTS_CUR_W-1:0]   phase_a_current_im,
	input  wire logic signed [`CTS_CUR_W-1:0]   phase_b_current_re,
	input  wire logic signed [`CTS_CUR_W-1:0]   phase_b_current_im,
	input  wire logic signed [`CTS_CUR_W-1:0]   phase_c_current_re,
	input  wire logic signed [`CTS_CUR_W-1:0]   phase_c_current_im,
	input  wire logic signed [`CTS_CUR_W-1:0]   residual_channel_one_re,
	input  wire logic signed [`CTS_CUR_W-1:0]   residual_channel_one_im,
	input  wire logic signed [`CTS_CUR_W-1:0]   residual_channel_two_re,
	input  wire logic signed [`CTS_CUR_W-1:0]   residual_channel_two_im,
	input  wire logic                           block_in,
	input  wire logic                           forcing_enable,
	input  wire cts_pkg::force_e                force_status,
	input  wire cts_pkg::residual_sel_e         residual_select,
	input  wire logic                           residual_polarity,
	input  wire logic                           residual_monitor_enable,
	input  wire logic                           compensate,
	input  wire logic        [`CTS_CUR_W-1:0]   upper_phase_threshold,
	input  wire logic        [`CTS_CUR_W-1:0]   lower_phase_threshold,
	input  wire logic        [`CTS_RATIO_W-1:0] phase_min_max_ratio_threshold,
	input  wire logic        [`CTS_RATIO_W-1:0] sequence_ratio_threshold,
	input  wire logic        [`CTS_CUR_W-1:0]   sum_mismatch_threshold,
	input  wire logic        [`CTS_DELAY_W-1:0] alarm_delay_ms,
	output logic                                start,
	output logic                                alarm,
	output logic                                blocked,
	output logic                                cycle_done,
	output logic             [`CTS_WIDE_W-1:0]  sum_difference
);
	localparam int W = `CTS_WIDE_W;

	logic [31:0]                   tick_count;
	logic                          tick;
	logic                          upd;
	logic                          eval;
	logic signed [W-1:0]           ph_re [3];
	logic signed [W-1:0]           ph_im [3];
	logic signed [W-1:0]           res_re;
	logic signed [W-1:0]           res_im;
	logic                          block_sample;
	logic                          res_used;
	logic                          comp_pending;
	logic signed [W-1:0]           offset_re;
	logic signed [W-1:0]           offset_im;
	logic signed [W-1:0]           raw_sum_re;
	logic signed [W-1:0]           raw_sum_im;
	logic signed [W-1:0]           vec_re [6];
	logic signed [W-1:0]           vec_im [6];
	logic        [W-1:0]           mag [6];
	logic        [16:0]            high_drop;
	logic        [16:0]            low_drop;
	logic        [16:0]            low_rise;
	logic        [2:0]             over_high;
	logic        [2:0]             above_low;
	logic        [2:0]             below_low;
	logic        [W-1:0]           mag_min;
	logic        [W-1:0]           mag_max;
	logic                          ratio_ok;
	logic                          seq_ok;
	logic                          sum_ok;
	logic                          cond_all;
	logic        [`CTS_DELAY_W:0]  elapsed;
	logic        [`CTS_DELAY_W:0]  next_elapsed;
	cts_pkg::state_e               state;
	cts_pkg::state_e               next_state;

	// processing time base; inputs are refreshed once per tick
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			tick_count <= 32'h0;
			tick <= 1'b0;
		end else if (tick_count >= TICK_CYCLES - 1) begin
			tick_count <= 32'h0;
			tick <= 1'b1;
		end else begin
			tick_count <= tick_count + 32'h1;
			tick <= 1'b0;
		end
	end

	// three-step pipeline: sample, update flags, evaluate state
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			upd <= 1'b0;
			eval <= 1'b0;
			cycle_done <= 1'b0;
		end else begin
			upd <= tick;
			eval <= upd;
			cycle_done <= eval;
		end
	end

	// sample measurements, block and general settings together at the tick
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < 3; i++) begin
				ph_re[i] <= '0;
				ph_im[i] <= '0;
			end
			res_re <= '0;
			res_im <= '0;
			block_sample <= 1'b0;
			res_used <= 1'b0;
		end else if (tick) begin
			ph_re[0] <= W'(phase_a_current_re);
			ph_im[0] <= W'(phase_a_current_im);
			ph_re[1] <= W'(phase_b_current_re);
			ph_im[1] <= W'(phase_b_current_im);
			ph_re[2] <= W'(phase_c_current_re);
			ph_im[2] <= W'(phase_c_current_im);
			block_sample <= block_in;
			// general settings are plain ports with no group select
			res_used <= residual_monitor_enable && residual_select != cts_pkg::RES_NONE;
			unique case (residual_select)
				cts_pkg::RES_ONE: begin
					res_re <= residual_polarity ? -W'(residual_channel_one_re)
						: W'(residual_channel_one_re);
					res_im <= residual_polarity ? -W'(residual_channel_one_im)
						: W'(residual_channel_one_im);
				end
				cts_pkg::RES_TWO: begin
					res_re <= residual_polarity ? -W'(residual_channel_two_re)
						: W'(residual_channel_two_re);
					res_im <= residual_polarity ? -W'(residual_channel_two_im)
						: W'(residual_channel_two_im);
				end
				default: begin
					res_re <= '0;
					res_im <= '0;
				end
			endcase
		end
	end

	// vector sum of phases and residual; a healthy circuit sums to zero
	always_comb begin
		raw_sum_re = ph_re[0] + ph_re[1] + ph_re[2] + res_re;
		raw_sum_im = ph_im[0] + ph_im[1] + ph_im[2] + res_im;
		vec_re[0] = ph_re[0];
		vec_im[0] = ph_im[0];
		vec_re[1] = ph_re[1];
		vec_im[1] = ph_im[1];
		vec_re[2] = ph_re[2];
		vec_im[2] = ph_im[2];
		vec_re[5] = raw_sum_re - offset_re;
		vec_im[5] = raw_sum_im - offset_im;
	end

	sequence_calc u_seq (
		.a_re   (ph_re[0]),
		.a_im   (ph_im[0]),
		.b_re   (ph_re[1]),
		.b_im   (ph_im[1]),
		.c_re   (ph_re[2]),
		.c_im   (ph_im[2]),
		.pos_re (vec_re[3]),
		.pos_im (vec_im[3]),
		.neg_re (vec_re[4]),
		.neg_im (vec_im[4])
	);

	// magnitudes: phases 0..2, positive 3, negative 4, compensated sum 5
	for (genvar g = 0; g < 6; g++) begin : g_mag
		mag_approx u_mag (
			.re  (vec_re[g]),
			.im  (vec_im[g]),
			.mag (mag[g])
		);
	end

	// release points of the hysteresis, relative to each threshold
	always_comb begin
		high_drop = 17'((24'(upper_phase_threshold) * 24'd`CTS_HYST_DROP_PCT) / 24'd`CTS_PCT_DIV);
		low_drop = 17'((24'(lower_phase_threshold) * 24'd`CTS_HYST_DROP_PCT) / 24'd`CTS_PCT_DIV);
		low_rise = 17'((24'(lower_phase_threshold) * 24'd`CTS_HYST_RISE_PCT) / 24'd`CTS_PCT_DIV);
	end

	// per-phase threshold flags with hysteresis so a value on the edge does not chatter
	for (genvar p = 0; p < 3; p++) begin : g_phase
		always_ff @(posedge clk or posedge reset) begin
			if (reset) begin
				over_high[p] <= 1'b0;
				above_low[p] <= 1'b0;
				below_low[p] <= 1'b0;
			end else if (upd) begin
				if (mag[p] > W'(upper_phase_threshold))
					over_high[p] <= 1'b1;
				else if (mag[p] < W'(high_drop))
					over_high[p] <= 1'b0;
				if (mag[p] > W'(lower_phase_threshold))
					above_low[p] <= 1'b1;
				else if (mag[p] < W'(low_drop))
					above_low[p] <= 1'b0;
				if (mag[p] < W'(lower_phase_threshold))
					below_low[p] <= 1'b1;
				else if (mag[p] > W'(low_rise))
					below_low[p] <= 1'b0;
			end
		end
	end

	// smallest and largest phase magnitude
	always_comb begin
		mag_min = mag[0];
		mag_max = mag[0];
		for (int i = 1; i < 3; i++) begin
			if (mag[i] < mag_min)
				mag_min = mag[i];
			if (mag[i] > mag_max)
				mag_max = mag[i];
		end
	end

	// ratio and sum checks, cross-multiplied to avoid a divider
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ratio_ok <= 1'b0;
			seq_ok <= 1'b0;
			sum_ok <= 1'b0;
			sum_difference <= '0;
		end else if (upd) begin
			ratio_ok <= (mag_max != '0) && (`CTS_PROD_W'(mag_min) * `CTS_PROD_W'(`CTS_RATIO_FULL)
				< `CTS_PROD_W'(mag_max) * `CTS_PROD_W'(phase_min_max_ratio_threshold));
			seq_ok <= `CTS_PROD_W'(mag[4]) * `CTS_PROD_W'(`CTS_RATIO_FULL)
				> `CTS_PROD_W'(mag[3]) * `CTS_PROD_W'(sequence_ratio_threshold);
			sum_ok <= mag[5] > W'(sum_mismatch_threshold);
			sum_difference <= mag[5];
		end
	end

	// compensate request is held until the next update; a new request wins over the clear
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			comp_pending <= 1'b0;
			offset_re <= `CTS_OFFSET_RST;
			offset_im <= `CTS_OFFSET_RST;
		end else begin
			if (compensate)
				comp_pending <= 1'b1;
			else if (upd)
				comp_pending <= 1'b0;
			// energized means some phase carries more than the lower threshold
			if (upd && comp_pending && (mag[0] > W'(lower_phase_threshold)
				|| mag[1] > W'(lower_phase_threshold) || mag[2] > W'(lower_phase_threshold))) begin
				offset_re <= raw_sum_re;
				offset_im <= raw_sum_im;
			end
		end
	end

	// all qualifying conditions; the sum check only counts when residual is in use
	always_comb begin
		cond_all = ~|over_high && |above_low && |below_low && ratio_ok && seq_ok
			&& (!res_used || sum_ok);
		next_elapsed = elapsed + (`CTS_DELAY_W+1)'(`CTS_TICK_MS);
	end

	// status decision once per processing cycle
	always_comb begin
		next_state = state;
		if (forcing_enable) begin
			unique case (force_status)
				cts_pkg::FORCE_ALARM: next_state = cts_pkg::ST_ALARM;
				cts_pkg::FORCE_BLOCKED: next_state = cts_pkg::ST_BLOCKED;
				default: next_state = cts_pkg::ST_NORMAL;
			endcase
		end else if (block_sample)
			next_state = cts_pkg::ST_BLOCKED;
		else if (!cond_all)
			next_state = cts_pkg::ST_NORMAL;
		else if (next_elapsed >= (`CTS_DELAY_W+1)'(alarm_delay_ms))
			next_state = cts_pkg::ST_ALARM;
		else
			next_state = cts_pkg::ST_START;
	end

	// delay timer counts only while everything holds without a break
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			elapsed <= `CTS_ELAPSED_RST;
		else if (eval) begin
			if (forcing_enable || block_sample || !cond_all)
				elapsed <= `CTS_ELAPSED_RST;
			else if (elapsed < (`CTS_DELAY_W+1)'(alarm_delay_ms))
				elapsed <= next_elapsed;
		end
	end

	// state and registered outputs
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state <= cts_pkg::ST_NORMAL;
			start <= 1'b0;
			alarm <= 1'b0;
			blocked <= 1'b0;
		end else if (eval) begin
			state <= next_state;
			start <= next_state == cts_pkg::ST_START || next_state == cts_pkg::ST_ALARM;
			alarm <= next_state == cts_pkg::ST_ALARM;
			blocked <= next_state == cts_pkg::ST_BLOCKED;
		end
	end

endmodule : current_transformer_supervision

// File: tb/current_transformer_supervision_sva.sv
`include "cts_params.svh"

// port-level checks of the supervision block
module cts_checker #(
	parameter int TICK_CYCLES = 20
) (
	input wire logic                   clk,
	input wire logic                   reset,
	input wire logic                   block_in,
	input wire logic                   forcing_enable,
	input wire cts_pkg::force_e        force_status,
	input wire logic                   start,
	input wire logic                   alarm,
	input wire logic                   blocked,
	input wire logic                   cycle_done,
	input wire logic [`CTS_WIDE_W-1:0] sum_difference
);
	timeunit 1ns;
	timeprecision 1ns;

	int              bcnt;
	int              fcnt;
	cts_pkg::force_e fprev;

	default clocking @(posedge clk);
	endclocking
	default disable iff (reset);

	// block held without forcing; a short pulse may miss the tick, so only long holds count
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			bcnt <= 0;
		end else begin
			bcnt <= (block_in && !forcing_enable) ? bcnt + 1 : 0;
		end
	end

	// forced code held unchanged long enough to be read
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			fcnt  <= 0;
			fprev <= cts_pkg::FORCE_NORMAL;
		end else begin
			fcnt  <= (forcing_enable && force_status == fprev) ? fcnt + 1 : 0;
			fprev <= force_status;
		end
	end

	property p_period;
		cycle_done |-> ##TICK_CYCLES cycle_done;
	endproperty
	a_period: assert property (p_period) else $error("cycle period wrong");

	property p_pulse;
		cycle_done |=> !cycle_done [*8];
	endproperty
	a_pulse: assert property (p_pulse) else $error("done not a pulse");

	property p_hold;
		$changed({start, alarm, blocked}) |-> ##[0:1] cycle_done;
	endproperty
	a_hold: assert property (p_hold) else $error("status moved off cycle");

	property p_sum_hold;
		$changed(sum_difference) |-> ##[1:3] cycle_done;
	endproperty
	a_sum_hold: assert property (p_sum_hold) else $error("sum moved off cycle");

	property p_excl;
		!(alarm && blocked);
	endproperty
	a_excl: assert property (p_excl) else $error("alarm while blocked");

	property p_rst;
		$fell(reset) |-> (!start && !alarm && !blocked) [*8];
	endproperty
	a_rst: assert property (p_rst) else $error("status early after reset");

	property p_block;
		cycle_done && bcnt > TICK_CYCLES + 8 |-> blocked && !start && !alarm;
	endproperty
	a_block: assert property (p_block) else $error("block ignored");

	property p_f_alarm;
		cycle_done && fcnt > 8 |-> alarm == (force_status == cts_pkg::FORCE_ALARM);
	endproperty
	a_f_alarm: assert property (p_f_alarm) else $error("forced alarm wrong");

	property p_f_blk;
		cycle_done && fcnt > 8 |-> blocked == (force_status == cts_pkg::FORCE_BLOCKED);
	endproperty
	a_f_blk: assert property (p_f_blk) else $error("forced block wrong");

	c_alarm: cover property ($rose(alarm));
	c_block: cover property ($rose(blocked));
	c_start: cover property ($rose(start) && !alarm);

endmodule : cts_checker

// File: tb/test_current_transformer_supervision.sv
`include "cts_params.svh"

module test_current_transformer_supervision;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int TICK = 20;

	logic                         clk = 1'b0;
	logic                         reset = 1'b1;
	logic signed [`CTS_CUR_W-1:0] phase_a_current_re, phase_a_current_im;
	logic signed [`CTS_CUR_W-1:0] phase_b_current_re, phase_b_current_im;
	logic signed [`CTS_CUR_W-1:0] phase_c_current_re, phase_c_current_im;
	logic signed [`CTS_CUR_W-1:0] residual_channel_one_re, residual_channel_one_im;
	logic signed [`CTS_CUR_W-1:0] residual_channel_two_re, residual_channel_two_im;
	logic                         block_in, forcing_enable, residual_polarity;
	logic                         residual_monitor_enable, compensate;
	cts_pkg::force_e              force_status;
	cts_pkg::residual_sel_e       residual_select;
	logic [`CTS_CUR_W-1:0]        upper_phase_threshold, lower_phase_threshold;
	logic [`CTS_CUR_W-1:0]        sum_mismatch_threshold;
	logic [`CTS_RATIO_W-1:0]      phase_min_max_ratio_threshold, sequence_ratio_threshold;
	logic [`CTS_DELAY_W-1:0]      alarm_delay_ms;
	logic                         start, alarm, blocked, cycle_done;
	logic [`CTS_WIDE_W-1:0]       sum_difference;
	int                           error_cnt = 0;
	int                           num_checks = 0;
	logic [31:0]                  seed = 32'h0000003C;

	// free-running 25 MHz clock
	always #20 clk = ~clk;

	current_transformer_supervision #(.TICK_CYCLES(TICK)) i_current_transformer_supervision (
		.clk, .reset, .phase_a_current_re, .phase_a_current_im, .phase_b_current_re,
		.phase_b_current_im, .phase_c_current_re, .phase_c_current_im,
		.residual_channel_one_re, .residual_channel_one_im, .residual_channel_two_re,
		.residual_channel_two_im, .block_in, .forcing_enable, .force_status, .residual_select,
		.residual_polarity, .residual_monitor_enable, .compensate, .upper_phase_threshold,
		.lower_phase_threshold, .phase_min_max_ratio_threshold, .sequence_ratio_threshold,
		.sum_mismatch_threshold, .alarm_delay_ms, .start, .alarm, .blocked, .cycle_done,
		.sum_difference);

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	task automatic print_verdict();
		$display("checks %0d, errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : print_verdict

	task automatic chk_flags(input logic [2:0] got, input logic [2:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: status %b, want %b", $time, got, exp);
		end
	endtask : chk_flags

	task automatic chk_sum(input logic [`CTS_WIDE_W-1:0] got, input logic [`CTS_WIDE_W-1:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: sum %0h, want %0h", $time, got, exp);
		end
	endtask : chk_sum

	// ends on a falling edge while the results of a cycle are shown
	task automatic wait_done();
		int n;
		n = 0;
		@(negedge clk);
		while (cycle_done !== 1'b1 && n < 4 * TICK) begin
			@(negedge clk);
			n++;
		end
		if (n >= 4 * TICK) begin
			error_cnt++;
			$display("mismatch at %0t: no cycle done", $time);
		end
	endtask : wait_done

	// b and c stay 1000 at -120 and +120 degrees; forcing stays off with alarm code set
	task automatic dflt(input logic [15:0] a);
		phase_a_current_re <= a;
		phase_a_current_im <= 16'h0000;
		phase_b_current_re <= 16'hFE0C;
		phase_b_current_im <= 16'hFC9E;
		phase_c_current_re <= 16'hFE0C;
		phase_c_current_im <= 16'h0362;
		residual_channel_one_re <= 16'h0000;
		residual_channel_one_im <= 16'h0000;
		residual_channel_two_re <= 16'(rnd() % 64);
		residual_channel_two_im <= 16'h0000;
		block_in <= 1'b0;
		forcing_enable <= 1'b0;
		force_status <= cts_pkg::FORCE_ALARM;
		residual_select <= cts_pkg::RES_NONE; // phases are never summed into a residual here
		residual_polarity <= 1'b0;
		residual_monitor_enable <= 1'b0;
		compensate <= 1'b0;
		upper_phase_threshold <= 16'h05DC;
		lower_phase_threshold <= 16'h0064;
		phase_min_max_ratio_threshold <= 14'h03E8;
		sequence_ratio_threshold <= 14'h1324;
		sum_mismatch_threshold <= 16'h0064;
		alarm_delay_ms <= 21'(rnd() % 23);
	endtask : dflt

	// each qualifying cycle adds 5 ms to the elapsed delay
	task automatic obs(input logic q, input int n);
		int k;
		for (int i = 1; i <= n; i++) begin
			wait_done();
			k = (alarm_delay_ms <= 21'h5) ? 1 : int'((alarm_delay_ms + 21'h4) / 21'h5);
			if (block_in === 1'b1) begin
				chk_flags({start, alarm, blocked}, 3'b001);
			end else begin
				chk_flags({start, alarm, blocked}, {q, q && i >= k, 1'b0});
			end
		end
	endtask : obs

	// balanced cycle first, so every case starts with a cleared delay
	task automatic pre(input logic [15:0] a);
		@(posedge clk);
		dflt(16'h03E8);
		obs(1'b0, 1);
		@(posedge clk);
		phase_a_current_re <= a;
	endtask : pre

	task automatic thr(input logic [15:0] a, input logic [15:0] up, input logic [15:0] lo,
		input logic [13:0] rt, input logic [13:0] sq, input logic q);
		pre(a);
		upper_phase_threshold <= up;
		lower_phase_threshold <= lo;
		phase_min_max_ratio_threshold <= rt;
		sequence_ratio_threshold <= sq;
		obs(q, 2);
	endtask : thr

	task automatic sumcase(input logic m, input cts_pkg::residual_sel_e s, input logic p,
		input logic [15:0] r, input logic q);
		pre(16'h0000);
		residual_monitor_enable <= m;
		residual_select <= s;
		residual_polarity <= p;
		residual_channel_one_re <= r;
		residual_channel_two_re <= 16'h03E8;
		obs(q, 2);
	endtask : sumcase

	// watchdog, far beyond the expected run length
	initial begin
		repeat (1000 * TICK) @(posedge clk);
		error_cnt++;
		$display("mismatch at %0t: run timed out", $time);
		print_verdict();
	end

	initial begin
		dflt(16'h03E8);
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		for (int r = 0; r < 4; r++) begin
			pre(16'h0000);
			obs(1'b1, 5);
		end
		thr(16'h0000, 16'h03E8, 16'h0064, 14'h03E8, 14'h1324, 1'b0);
		thr(16'h0000, 16'h05DC, 16'h04B0, 14'h03E8, 14'h1324, 1'b0);
		thr(16'h0032, 16'h05DC, 16'h0064, 14'h03E8, 14'h0BB8, 1'b1);
		thr(16'h0032, 16'h05DC, 16'h0064, 14'h0190, 14'h0BB8, 1'b0);
		thr(16'h0000, 16'h05DC, 16'h0064, 14'h03E8, 14'h13EC, 1'b0);
		pre(16'h0000);
		alarm_delay_ms <= 21'h00000F;
		obs(1'b1, 2);
		pre(16'h0000);
		alarm_delay_ms <= 21'h00000F;
		obs(1'b1, 3);
		pre(16'h0000);
		block_in <= 1'b1;
		obs(1'b1, 2);
		for (int f = 0; f < 4; f++) begin
			pre(16'h0000);
			forcing_enable <= 1'b1;
			force_status <= cts_pkg::force_e'(f);
			block_in <= 1'b1;
			wait_done();
			chk_flags({start, alarm, blocked}, {f == 1, f == 1, f == 2});
		end
		sumcase(1'b1, cts_pkg::RES_ONE, 1'b0, 16'h03E8, 1'b0);
		sumcase(1'b1, cts_pkg::RES_ONE, 1'b1, 16'h03E8, 1'b1);
		sumcase(1'b1, cts_pkg::RES_TWO, 1'b0, 16'h0000, 1'b0);
		sumcase(1'b1, cts_pkg::RES_NONE, 1'b0, 16'h03E8, 1'b1);
		sumcase(1'b0, cts_pkg::RES_ONE, 1'b0, 16'h03E8, 1'b1);
		sumcase(1'b1, cts_pkg::RES_ONE, 1'b0, 16'h0000, 1'b1);
		chk_sum(sum_difference, 20'h003E8);
		@(posedge clk);
		compensate <= 1'b1;
		@(posedge clk);
		compensate <= 1'b0;
		// the offset is stored at the update edge, so the readback of that cycle is still raw
		wait_done();
		chk_sum(sum_difference, 20'h003E8);
		obs(1'b0, 1);
		chk_sum(sum_difference, 20'h00000);
		// second reset must also drop the stored offset
		@(posedge clk);
		reset <= 1'b1;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		@(negedge clk);
		chk_flags({start, alarm, blocked}, 3'b000);
		sumcase(1'b1, cts_pkg::RES_ONE, 1'b0, 16'h0000, 1'b1);
		chk_sum(sum_difference, 20'h003E8);
		print_verdict();
	end

endmodule : test_current_transformer_supervision

bind current_transformer_supervision cts_checker #(.TICK_CYCLES(TICK_CYCLES)) i_cts_checker (
	.clk, .reset, .block_in, .forcing_enable, .force_status, .start, .alarm, .blocked,
	.cycle_done, .sum_difference);
